// file: bench/adcir_host.sv
module adcir_host (
  input wire logic clk,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {wr_en, rd_en, addr, wdata} = 18'h0;
  // One access, held through its taking edge, then lines scrambled
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= w;
    rd_en <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : acc
endmodule : adcir_host

// file: bench/adcir_regs_tb.sv
module adcir_regs_tb;
  import adcir_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, wr_en, rd_en, nrdy, rail, pc, nc;
  logic [7:0] addr, wdata, rdata, w;
  logic [1:0] refe;
  logic [3:0] ps, ns;
  adcir_det_t det;
  logic [7:0] q[$];
  logic [31:0] rng = 32'h31;
  logic [31:0] r;
  logic pend = 1'b0;
  int mismatches, comparisons;
  adcir_regs #(.MODEL_CODE(3'h2), .RESERVED_ID(5'h0A)) i_dut (.SYS_CLK(clk),
    .SRST(srst), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata),
    .NOT_READY(nrdy), .DET(det), .RAIL_MONITOR_ENABLE(rail),
    .REF_MONITOR_ENABLE(refe), .RDATA(rdata), .POSITIVE_INPUT_SELECT(ps),
    .NEGATIVE_INPUT_SELECT(ns), .POS_IS_COMMON(pc), .NEG_IS_COMMON(nc));
  adcir_host i_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string n);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic [31:0] nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : nxt
  function automatic logic [7:0] st(input logic por);
    return {por, nrdy, rail ? det[5:2] : 4'h0, refe[1] & det[1], |refe & det[0]};
  endfunction : st
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    i_host.acc(1'b0, a, 8'h00);
  endtask : rd
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  // Read data is compared one edge after the read is taken
  always @(posedge clk)
  begin
    if (pend)
      chk(rdata, q.pop_front(), "rdata");
    pend <= rd_en;
  end
  initial
  begin
    #100000;
    mismatches++;
    print_verdict();
  end
  initial
  begin
    {srst, nrdy, rail, refe, det} = 11'h400;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rd(8'h02, 8'h01);
    rd(8'h01, 8'h80);
    rd(8'h00, 8'h52);
    rd(8'h07, 8'h00);
    i_host.acc(1'b1, 8'h00, 8'hFF);
    rd(8'h00, 8'h52);
    i_host.acc(1'b1, 8'h01, 8'hFF);
    rd(8'h01, st(1'b1));
    i_host.acc(1'b1, 8'h01, 8'h00);
    rd(8'h01, st(1'b0));
    for (int i = 0; i < 24; i++)
    begin
      r = nxt();
      {w, det, rail, refe, nrdy} <= r[17:0];
      // Detector levels must pass the input filter before the read
      repeat (2) @(posedge clk);
      if (i == 0)
        w = 8'hCC;
      rd(8'h01, st(1'b0));
      rd(8'h01, st(1'b0));
      i_host.acc(1'b1, 8'h02, w);
      rd(8'h02, w);
      chk({ps, ns}, w, "selects");
      chk({pc, nc}, {w[7:4] == ADCIR_SEL_COMMON,
        w[3:0] == ADCIR_SEL_COMMON}, "common");
    end
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(8'h01, st(1'b1));
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule : adcir_regs_tb

// file: shared/adcir_pkg.sv
package adcir_pkg;
  localparam logic [7:0] ADCIR_ADDR_ID = 8'h00;
  localparam logic [7:0] ADCIR_ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADCIR_ADDR_INSEL = 8'h02;
  localparam logic [7:0] ADCIR_STATUS_RST = 8'h80;
  localparam logic [7:0] ADCIR_INSEL_RST = 8'h01;
  localparam int ADCIR_POR_BIT = 7;
  localparam int ADCIR_RDY_BIT = 6;
  localparam logic [3:0] ADCIR_SEL_LAST_AIN = 4'hB;
  localparam logic [3:0] ADCIR_SEL_COMMON = 4'hC;
  localparam logic [1:0] ADCIR_REFMON_OFF = 2'h0;
  localparam logic [1:0] ADCIR_REFMON_L0 = 2'h1;
  localparam int ADCIR_POS_HIGH_BIT = 5;
  localparam int ADCIR_POS_LOW_BIT = 4;
  localparam int ADCIR_NEG_HIGH_BIT = 3;
  localparam int ADCIR_NEG_LOW_BIT = 2;
  localparam int ADCIR_THIRD_BIT = 1;
  localparam int ADCIR_MISS_BIT = 0;
  localparam logic [7:0] ADCIR_RDATA_RST = 8'h00;
  localparam logic [7:0] ADCIR_UNMAPPED_RD = 8'h00;

  typedef struct packed {
    logic pos_high;
    logic pos_low;
    logic neg_high;
    logic neg_low;
    logic ref_third;
    logic ref_missing;
  } adcir_det_t;

  typedef struct packed {
    logic not_ready;
    adcir_det_t det;
  } adcir_live_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic power_on_flag;
    logic [3:0] positive_input_select;
    logic [3:0] negative_input_select;
    logic pos_common;
    logic neg_common;
    adcir_live_t sync_1;
    adcir_live_t sync_2;
    adcir_live_t sync_3;
    adcir_live_t held;
  } adcir_state_t;
endpackage : adcir_pkg

// file: verilog/adcir_regs.sv
module adcir_regs
  import adcir_pkg::*;
#(
  parameter logic [2:0] MODEL_CODE = 3'h0, // Arbitrary neutral value
  parameter logic [4:0] RESERVED_ID = 5'h00
)(
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic NOT_READY,
  input wire adcir_det_t DET,
  input wire logic RAIL_MONITOR_ENABLE,
  input wire logic [1:0] REF_MONITOR_ENABLE,
  output logic [7:0] RDATA,
  output logic [3:0] POSITIVE_INPUT_SELECT,
  output logic [3:0] NEGATIVE_INPUT_SELECT,
  output logic POS_IS_COMMON,
  output logic NEG_IS_COMMON
);
  adcir_state_t s_q;
  adcir_state_t s_d;
  adcir_live_t live;
  logic [7:0] status;
  logic [7:0] ident;
  logic rail_ok;
  logic third_ok;
  logic miss_ok;
  logic id_rd;
  logic st_rd;
  logic sel_rd;
  logic st_wr;
  logic sel_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Input filter: a change counts once the second and third stages agree
  always_comb
  begin
    if (s_q.sync_2 == s_q.sync_3)
      live = s_q.sync_3;
    else
      live = s_q.held;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  always_comb
  begin
    id_rd = 1'b0;
    st_rd = 1'b0;
    sel_rd = 1'b0;
    st_wr = 1'b0;
    sel_wr = 1'b0;
    if (ADDR == ADCIR_ADDR_ID)
      id_rd = RD_EN;
    else if (ADDR == ADCIR_ADDR_STATUS)
    begin
      st_rd = RD_EN;
      st_wr = WR_EN;
    end
    else if (ADDR == ADCIR_ADDR_INSEL)
    begin
      sel_rd = RD_EN;
      sel_wr = WR_EN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitor gating and read views
  always_comb
  begin
    rail_ok = RAIL_MONITOR_ENABLE;
    third_ok = (REF_MONITOR_ENABLE != ADCIR_REFMON_OFF) &&
               (REF_MONITOR_ENABLE != ADCIR_REFMON_L0);
    miss_ok = (REF_MONITOR_ENABLE != ADCIR_REFMON_OFF);
    ident = {RESERVED_ID, MODEL_CODE};
    status[ADCIR_POR_BIT] = s_q.power_on_flag;
    status[ADCIR_RDY_BIT] = live.not_ready;
    status[ADCIR_POS_HIGH_BIT] = live.det.pos_high & rail_ok;
    status[ADCIR_POS_LOW_BIT] = live.det.pos_low & rail_ok;
    status[ADCIR_NEG_HIGH_BIT] = live.det.neg_high & rail_ok;
    status[ADCIR_NEG_LOW_BIT] = live.det.neg_low & rail_ok;
    status[ADCIR_THIRD_BIT] = live.det.ref_third & third_ok;
    status[ADCIR_MISS_BIT] = live.det.ref_missing & miss_ok;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.sync_1.not_ready = NOT_READY;
    s_d.sync_1.det = DET;
    s_d.sync_2 = s_q.sync_1;
    s_d.sync_3 = s_q.sync_2;
    s_d.held = live;
    if (id_rd)
      s_d.rdata = ident;
    else if (st_rd)
      s_d.rdata = status;
    else if (sel_rd)
      s_d.rdata = {s_q.positive_input_select, s_q.negative_input_select};
    else if (RD_EN)
      s_d.rdata = ADCIR_UNMAPPED_RD;
    // Only the power-on flag of status takes write data
    if (st_wr)
    begin
      // Writing zero clears; writing one leaves the flag as it is
      s_d.power_on_flag = s_q.power_on_flag &
                          WDATA[ADCIR_POR_BIT];
    end
    if (sel_wr)
    begin
      s_d.positive_input_select = WDATA[7:4];
      s_d.negative_input_select = WDATA[3:0];
    end
    s_d.pos_common =
      (s_d.positive_input_select == ADCIR_SEL_COMMON);
    s_d.neg_common =
      (s_d.negative_input_select == ADCIR_SEL_COMMON);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      s_q.rdata <= ADCIR_RDATA_RST;
      s_q.power_on_flag <= ADCIR_STATUS_RST[ADCIR_POR_BIT];
      s_q.positive_input_select <= ADCIR_INSEL_RST[7:4];
      s_q.negative_input_select <= ADCIR_INSEL_RST[3:0];
      s_q.pos_common <= 1'b0;
      s_q.neg_common <= 1'b0;
      s_q.sync_1 <= '0;
      s_q.sync_2 <= '0;
      s_q.sync_3 <= '0;
      s_q.held <= '0;
    end
    else
      s_q <= s_d;
  end

  assign RDATA = s_q.rdata;
  assign POSITIVE_INPUT_SELECT = s_q.positive_input_select;
  assign NEGATIVE_INPUT_SELECT = s_q.negative_input_select;
  assign POS_IS_COMMON = s_q.pos_common;
  assign NEG_IS_COMMON = s_q.neg_common;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  a_por_after_reset: assert property (
    $fell(SRST) |-> s_q.power_on_flag)
    else $error("power-on flag not set after reset");
  a_por_stays_clear: assert property (
    !s_q.power_on_flag |=> !s_q.power_on_flag)
    else $error("power-on flag set again without reset");
  a_por_clear_write: assert property (
    st_wr && !WDATA[ADCIR_POR_BIT] |=> !s_q.power_on_flag)
    else $error("power-on flag not cleared by write");
  a_por_keep_write: assert property (
    st_wr && WDATA[ADCIR_POR_BIT] |=> $stable(s_q.power_on_flag))
    else $error("power-on flag changed by writing one");
  a_por_readback: assert property (
    st_rd |=> RDATA[ADCIR_POR_BIT] == $past(s_q.power_on_flag))
    else $error("power-on flag readback wrong");

  a_ready_bit: assert property (
    st_rd |=> RDATA[ADCIR_RDY_BIT] == $past(live.not_ready))
    else $error("ready bit wrong");
  a_rail_report: assert property (
    st_rd && RAIL_MONITOR_ENABLE |=> RDATA[5:2] == $past(live.det[5:2]))
    else $error("rail flags wrong while enabled");
  a_rail_gated: assert property (
    st_rd && !RAIL_MONITOR_ENABLE |=> RDATA[5:2] == 4'h0)
    else $error("rail flag reported while disabled");
  a_ref_gated: assert property (
    st_rd && REF_MONITOR_ENABLE == ADCIR_REFMON_OFF |=> RDATA[1:0] == 2'h0)
    else $error("reference flag reported while disabled");
  a_third_gated: assert property (
    st_rd && REF_MONITOR_ENABLE == ADCIR_REFMON_L0 |=>
    !RDATA[ADCIR_THIRD_BIT])
    else $error("one-third flag reported while disabled");
  a_third_report: assert property (
    st_rd && third_ok |=> RDATA[ADCIR_THIRD_BIT] == $past(live.det.ref_third))
    else $error("one-third flag wrong while enabled");
  a_miss_report: assert property (
    st_rd && miss_ok |=> RDATA[ADCIR_MISS_BIT] == $past(live.det.ref_missing))
    else $error("missing-reference flag wrong while enabled");
  a_id_value: assert property (
    id_rd |=> RDATA == {RESERVED_ID, MODEL_CODE})
    else $error("identity readback wrong");
  a_unmapped_read: assert property (
    RD_EN && ADDR > ADCIR_ADDR_INSEL |=> RDATA == ADCIR_UNMAPPED_RD)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (
    !RD_EN |=> $stable(RDATA))
    else $error("read data changed without a read");
  a_insel_write: assert property (
    sel_wr |=> {POSITIVE_INPUT_SELECT, NEGATIVE_INPUT_SELECT} == $past(WDATA))
    else $error("input select write lost");
  a_insel_hold: assert property (
    !sel_wr |=> $stable(POSITIVE_INPUT_SELECT) &&
    $stable(NEGATIVE_INPUT_SELECT))
    else $error("input select changed without write");
  a_common_flag: assert property (
    POS_IS_COMMON == (POSITIVE_INPUT_SELECT == ADCIR_SEL_COMMON) &&
    NEG_IS_COMMON == (NEGATIVE_INPUT_SELECT == ADCIR_SEL_COMMON))
    else $error("common input flag wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Coverage
  c_por_clear: cover property (s_q.power_on_flag ##1 !s_q.power_on_flag);
  c_rail_read: cover property (st_rd && rail_ok && |live.det[5:2]);
  c_third_read: cover property (st_rd && third_ok && live.det.ref_third);
  c_common_sel: cover property (s_q.pos_common);
  c_id_read: cover property (id_rd);
endmodule : adcir_regs
